// file: core/eip_pkg.sv
/*
  shared constants and the state type of the external interrupt pin unit.
  assumes a 32-bit avalon-mm data path with byte addressing.
*/
package eip_pkg;

  //////////////////////////////////////////////////////////////////////
  // bus geometry and register offsets (byte addresses)
  localparam int         EIP_DW       = 32;
  localparam logic [3:0] EIP_OFS_CTRL = 4'h0;
  localparam logic [3:0] EIP_OFS_BRK  = 4'h4;

  //////////////////////////////////////////////////////////////////////
  // field positions
  localparam int EIP_POS_PEND = 3;
  localparam int EIP_POS_ACK  = 2;
  localparam int EIP_POS_MASK = 1;
  localparam int EIP_POS_MODE = 0;
  localparam int EIP_POS_BCE  = 7;

  //////////////////////////////////////////////////////////////////////
  // vector pair fetched when the request is taken
  localparam logic [15:0] EIP_VEC_LO_ADDR = 16'hfffa;
  localparam logic [15:0] EIP_VEC_HI_ADDR = 16'hfffb;

  //////////////////////////////////////////////////////////////////////
  // whole state of the unit
  typedef struct packed {
    logic              s1;
    logic              s2;
    logic              s3;
    logic              pin;
    logic              latch;
    logic              ack_seen;
    logic              mode;
    logic              mask;
    logic              bce;
    logic              wreq;
    logic [EIP_DW-1:0] rdata;
    logic              req;
    logic              pend;
    logic [15:0]       vec;
  } eip_state_t;

  // reset image: pin idles high, latch and all control bits clear
  localparam eip_state_t EIP_ST_RST = '{
    s1:       1'b1,
    s2:       1'b1,
    s3:       1'b1,
    pin:      1'b1,
    latch:    1'b0,
    ack_seen: 1'b0,
    mode:     1'b0,
    mask:     1'b0,
    bce:      1'b0,
    wreq:     1'b1,
    rdata:    32'h0000_0000,
    req:      1'b0,
    pend:     1'b0,
    vec:      16'hfffa
  };

endpackage

// file: core/eip_unit.sv
/*
  external interrupt pin unit: synchroniser, edge/level latch, mask,
  break protection and an avalon-mm slave for its two registers.
  assumes vector_ack, break_active and cpu_int_mask come from logic on clk;
  irq_pin_n is asynchronous and active low.
  only byte lane 0 carries fields; a write with that lane disabled is dropped.
  pin pulses shorter than the synchroniser depth may be missed, the price
  paid for filtering slow or noisy edges on the pin.
*/
`timescale 1ns/1ps


module eip_unit #(
  parameter int ADDR_W = 4
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      irq_pin_n,
  input  wire logic                      vector_ack,
  input  wire logic                      break_active,
  input  wire logic                      cpu_int_mask,
  input  wire logic [ADDR_W-1:0]         avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [eip_pkg::EIP_DW-1:0] avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [eip_pkg::EIP_DW-1:0] avs_readdata,
  output logic                           avs_waitrequest,
  output logic                           irq_request,
  output logic                           pending_flag,
  output logic      [15:0]               vector_addr
);
  import eip_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // elaboration check: decode needs at least the two word offsets
  if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr
    $error("eip_unit: ADDR_W must lie between 3 and 32");
  end

  eip_state_t st_q;
  eip_state_t st_d;

  logic pin_next;
  logic fall;
  logic bus_req;
  logic take;
  logic wr_ctrl;
  logic wr_brk;
  logic sw_ack;
  logic any_ack;
  logic ack_pend;
  logic set_ev;
  logic clr_ev;
  logic latch_d;
  logic mask_d;

  ////////////////////////////////////////////////////////////////////////
  // word decode, used by both the read and write paths
  function automatic logic f_hit(input logic [ADDR_W-1:0] a,
                                 input logic [3:0]        ofs);
    return 32'(a) == 32'(ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // filtered pin level: moves only once the 2nd and 3rd stage agree
  assign pin_next = (st_q.s2 == st_q.s3) ? st_q.s3 : st_q.pin;
  assign fall     = st_q.pin & ~pin_next;

  // bus handshake: a request is taken when waitrequest is already low
  assign bus_req = avs_read | avs_write;
  assign take    = bus_req & ~st_q.wreq;
  assign wr_ctrl = take & avs_write & avs_byteenable[0]
                 & f_hit(avs_address, EIP_OFS_CTRL);
  assign wr_brk  = take & avs_write & avs_byteenable[0]
                 & f_hit(avs_address, EIP_OFS_BRK);

  // software acknowledge, blocked in break unless clear is enabled
  assign sw_ack  = wr_ctrl & avs_writedata[EIP_POS_ACK]
                 & (~break_active | st_q.bce);
  assign any_ack = vector_ack | sw_ack;

  // level mode remembers an early acknowledge until the pin rises
  assign ack_pend = any_ack | st_q.ack_seen;

  // set always wins over a clear in the same cycle
  assign set_ev = fall | (st_q.mode & ~pin_next);
  assign clr_ev = st_q.mode ? (ack_pend & pin_next)
                            : any_ack;
  assign latch_d = set_ev | (st_q.latch & ~clr_ev);
  assign mask_d  = wr_ctrl ? avs_writedata[EIP_POS_MASK] : st_q.mask;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_d = st_q;
    // three-stage synchroniser; s1 feeds only s2
    st_d.s1  = irq_pin_n;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    st_d.pin = pin_next;

    st_d.latch = latch_d;
    // a fresh edge needs a fresh acknowledge
    st_d.ack_seen = latch_d & st_q.mode & ack_pend & ~fall;

    // control writes; the acknowledge bit itself is never stored
    if (wr_ctrl) begin
      st_d.mode = avs_writedata[EIP_POS_MODE];
      st_d.mask = avs_writedata[EIP_POS_MASK];
    end
    if (wr_brk) begin
      st_d.bce = avs_writedata[EIP_POS_BCE];
    end

    // one wait state, then answer; readdata is loaded on the way down
    st_d.wreq = ~(bus_req & st_q.wreq);
    if (bus_req & st_q.wreq) begin
      st_d.rdata = '0;
      if (avs_read & f_hit(avs_address, EIP_OFS_CTRL)) begin
        st_d.rdata[EIP_POS_PEND] = st_q.latch;
        st_d.rdata[EIP_POS_ACK]  = 1'b0;
        st_d.rdata[EIP_POS_MASK] = st_q.mask;
        st_d.rdata[EIP_POS_MODE] = st_q.mode;
      end
      if (avs_read & f_hit(avs_address, EIP_OFS_BRK)) begin
        st_d.rdata[EIP_POS_BCE] = st_q.bce;
      end
    end

    // request to the priority logic: both masks gate it
    st_d.req  = latch_d & ~mask_d & ~cpu_int_mask;
    st_d.pend = latch_d;
    st_d.vec  = EIP_VEC_LO_ADDR;
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; reset drops the latch even with the pin still low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= EIP_ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs come straight from the state flops
  assign avs_readdata    = st_q.rdata;
  assign avs_waitrequest = st_q.wreq;
  assign irq_request     = st_q.req;
  assign pending_flag    = st_q.pend;
  assign vector_addr     = st_q.vec;   // high byte of vector sits at +1

  ////////////////////////////////////////////////////////////////////////
  // checks
  // the checks watch design state and also the inputs that the bench drives
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // a settled falling edge shows as pending one edge later
  property p_fall_sets;
    fall |=> pending_flag;
  endproperty
  a_fall_sets: assert property (p_fall_sets)
    else $error("falling edge did not set pending");

  // edge mode: vector acknowledge clears at once
  property p_edge_clear;
    (!st_q.mode && vector_ack && !fall) |=> !st_q.latch && !pending_flag;
  endproperty
  a_edge_clear: assert property (p_edge_clear)
    else $error("edge mode acknowledge did not clear");

  // level mode: low pin holds the latch despite acknowledge
  property p_level_hold;
    (st_q.mode && !pin_next) |=> st_q.latch;
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("latch dropped while pin low in level mode");

  // level mode: acknowledge first, pin rises later, then clear
  sequence s_lvl_ack;
    st_q.mode && st_q.latch && any_ack && !pin_next;
  endsequence
  sequence s_lvl_rise;
    st_q.mode && pin_next && !fall;
  endsequence
  property p_level_order;
    s_lvl_ack ##1 s_lvl_rise |=> !st_q.latch;
  endproperty
  a_level_order: assert property (p_level_order)
    else $error("early acknowledge lost before pin rose");

  // request only when latched and neither mask blocks it
  property p_req_gate;
    irq_request |-> st_q.latch && !st_q.mask && ($past(cpu_int_mask) == 1'b0);
  endproperty
  a_req_gate: assert property (p_req_gate)
    else $error("request presented while masked");

  // masked but latched still shows pending
  property p_pend_masked;
    (st_q.latch && st_q.mask) |-> pending_flag && !irq_request;
  endproperty
  a_pend_masked: assert property (p_pend_masked)
    else $error("pending flag hidden by mask");

  // protected break: software acknowledge has no effect
  property p_brk_protect;
    (break_active && !st_q.bce && wr_ctrl && avs_writedata[EIP_POS_ACK]
     && !vector_ack && !st_q.ack_seen && st_q.latch) |=> st_q.latch;
  endproperty
  a_brk_protect: assert property (p_brk_protect)
    else $error("latch cleared in protected break");

  // enabled break clear works like outside break
  property p_brk_clear;
    (break_active && st_q.bce && wr_ctrl && avs_writedata[EIP_POS_ACK]
     && !st_q.mode && !fall) |=> !st_q.latch;
  endproperty
  a_brk_clear: assert property (p_brk_clear)
    else $error("break clear enable did not allow clear");

  // acknowledge bit always reads zero
  property p_ack_reads0;
    (avs_read && !avs_waitrequest) |-> !avs_readdata[EIP_POS_ACK];
  endproperty
  a_ack_reads0: assert property (p_ack_reads0)
    else $error("acknowledge bit read back as one");

  // every request is answered after one wait state
  property p_bus_answer;
    (bus_req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer timing wrong");

  ////////////////////////////////////////////////////////////////////////
  // synchroniser, mode, mask, vector, break and bus checks at the register level

  // the filtered level holds while the last two stages disagree
  property p_sync_hold;
    (st_q.s2 != st_q.s3) |=> $stable(st_q.pin);
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("filtered pin moved before stages agreed");

  // edge mode: no edge, no latch
  property p_edge_idle;
    (!st_q.mode && !st_q.latch && !fall) |=> !st_q.latch;
  endproperty
  a_edge_idle: assert property (p_edge_idle)
    else $error("latch set without a falling edge");

  // edge mode: the latch holds until an acknowledge
  property p_edge_hold;
    (!st_q.mode && st_q.latch && !any_ack) |=> st_q.latch;
  endproperty
  a_edge_hold: assert property (p_edge_hold)
    else $error("edge mode latch dropped without acknowledge");

  // level mode: a rising pin alone does not clear
  property p_level_no_ack;
    (st_q.mode && st_q.latch && !any_ack && !st_q.ack_seen) |=> st_q.latch;
  endproperty
  a_level_no_ack: assert property (p_level_no_ack)
    else $error("level mode latch cleared without acknowledge");

  // level mode: pin high first, then acknowledge, clears
  property p_level_pin_first;
    (st_q.mode && st_q.latch && pin_next && any_ack) |=> !st_q.latch;
  endproperty
  a_level_pin_first: assert property (p_level_pin_first)
    else $error("acknowledge after pin return did not clear");

  // a new falling edge drops a remembered acknowledge
  property p_ack_forget;
    fall |=> !st_q.ack_seen;
  endproperty
  a_ack_forget: assert property (p_ack_forget)
    else $error("remembered acknowledge survived a new edge");

  // vector pair: low byte address shown, high byte at the next address
  property p_vec_pair;
    (vector_addr == EIP_VEC_LO_ADDR) && ((vector_addr + 16'h0001) == EIP_VEC_HI_ADDR);
  endproperty
  a_vec_pair: assert property (p_vec_pair)
    else $error("vector address pair wrong");

  // the cpu global mask blocks the request on the next edge
  property p_cpu_mask;
    cpu_int_mask |=> !irq_request;
  endproperty
  a_cpu_mask: assert property (p_cpu_mask)
    else $error("request presented under cpu global mask");

  // writing the mask bit withholds the request at once
  property p_mask_block;
    (wr_ctrl && avs_writedata[EIP_POS_MASK]) |=> !irq_request;
  endproperty
  a_mask_block: assert property (p_mask_block)
    else $error("request presented after mask write");

  // an unmasked latch is presented on the next edge
  property p_req_present;
    (latch_d && !mask_d && !cpu_int_mask) |=> irq_request;
  endproperty
  a_req_present: assert property (p_req_present)
    else $error("unmasked request not presented");

  // bits 31:8 and 6:4 of both registers read zero
  property p_rd_fields;
    (avs_read && !avs_waitrequest)
      |-> (avs_readdata[EIP_DW-1:8] == '0) && (avs_readdata[6:4] == 3'h0);
  endproperty
  a_rd_fields: assert property (p_rd_fields)
    else $error("unused read bits not zero");

  // a control write sets the sensitivity bit as written
  property p_wr_mode;
    wr_ctrl |=> (st_q.mode == $past(avs_writedata[EIP_POS_MODE]));
  endproperty
  a_wr_mode: assert property (p_wr_mode)
    else $error("sensitivity bit not written");

  // a break register write sets break clear enable as written
  property p_wr_bce;
    wr_brk |=> (st_q.bce == $past(avs_writedata[EIP_POS_BCE]));
  endproperty
  a_wr_bce: assert property (p_wr_bce)
    else $error("break clear enable not written");

  // nothing is written while waitrequest is still high
  property p_no_early_write;
    (avs_write && avs_waitrequest)
      |=> $stable(st_q.mode) && $stable(st_q.mask) && $stable(st_q.bce);
  endproperty
  a_no_early_write: assert property (p_no_early_write)
    else $error("write took effect before the answer");

  // break never blocks the vector fetch acknowledge
  property p_brk_vec_clear;
    (break_active && vector_ack && !st_q.mode && !fall) |=> !st_q.latch;
  endproperty
  a_brk_vec_clear: assert property (p_brk_vec_clear)
    else $error("vector acknowledge blocked in break");

  // waitrequest stays high while the bus is idle
  property p_wait_rest;
    (!bus_req && avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_wait_rest: assert property (p_wait_rest)
    else $error("waitrequest dropped without a request");

endmodule

// file: verification/eip_pin_src.sv
/*
  pin source model: drives the active-low interrupt pin of the unit.
  assumes the bench calls drive() and that the pin idles high.
*/
`timescale 1ns/1ps
module eip_pin_src (
  input  wire logic clk,
  output logic      irq_pin_n
);
  //////////////////////////////////////////////////////////////////////
  // idle level is high, as a pull-up would hold it
  initial irq_pin_n = 1'b1;

  // levels change just after a rising edge and are held for many cycles,
  // because pulses shorter than the synchroniser depth may be lost
  task automatic drive(input logic v);
    @(posedge clk);
    irq_pin_n <= v;
  endtask
endmodule

// file: verification/testbench.sv
/*
  bench for eip_unit: avalon-mm tasks, pin source and a sequence of checks.
  assumes one wait state per access and a pin delay of a few cycles.
*/
`timescale 1ns/1ps
module testbench;
  import eip_pkg::*;
  logic              clk           = 1'b0;
  logic              rst           = 1'b1;
  logic              irq_pin_n;
  logic              vector_ack    = 1'b0;
  logic              break_active  = 1'b0;
  logic              cpu_int_mask  = 1'b0;
  logic [3:0]        avs_address   = 4'h0;
  logic              avs_read      = 1'b0;
  logic              avs_write     = 1'b0;
  logic [EIP_DW-1:0] avs_writedata = '0;
  logic [EIP_DW-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              irq_request;
  logic              pending_flag;
  logic [15:0]       vector_addr;
  int                miscompares   = 0;
  int                n_tests       = 0;
  int                cyc           = 0;

  //////////////////////////////////////////////////////////////////////
  always #20 clk = ~clk;

  eip_unit #(.ADDR_W(4)) u_dut (
    .clk(clk), .rst(rst), .irq_pin_n(irq_pin_n), .vector_ack(vector_ack),
    .break_active(break_active), .cpu_int_mask(cpu_int_mask),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_request(irq_request), .pending_flag(pending_flag),
    .vector_addr(vector_addr)
  );

  eip_pin_src u_src (.clk(clk), .irq_pin_n(irq_pin_n));

  //////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // a hung handshake would stall the sequence, so a cycle ceiling ends it
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up;
    end
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  // one access: held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    logic ws;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    // waitrequest is read mid-cycle, so the edge that updates it cannot race
    do begin
      @(negedge clk);
      ws = avs_waitrequest;
      @(posedge clk);
    end while (ws !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk("readdata", {24'h0, e}, q);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  // pin change plus time for the synchroniser to pass it on
  task automatic pin(input int v);
    u_src.drive(v[0]);
    wait_n(8);
  endtask

  // outputs are read mid-cycle, away from the edge that launches them
  task automatic flags(input int p, input int r);
    wait_n(2);
    @(negedge clk);
    chk("pending_flag", 32'(p), {31'h0, pending_flag});
    chk("irq_request", 32'(r), {31'h0, irq_request});
    @(posedge clk);
  endtask

  task automatic vec_ack;
    @(posedge clk);
    vector_ack <= 1'b1;
    @(posedge clk);
    vector_ack <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////
  // main sequence: reset image, edge mode, masks, level mode, break
  initial begin
    wait_n(6);
    rst <= 1'b0;
    flags(0, 0);
    chk("vector_addr", {16'h0, EIP_VEC_LO_ADDR}, {16'h0, vector_addr});
    rd(EIP_OFS_CTRL, 8'h00);
    rd(EIP_OFS_BRK, 8'h00);
    rd(4'h8, 8'h00);
    wr(EIP_OFS_CTRL, 8'h03);
    rd(EIP_OFS_CTRL, 8'h03);
    wr(EIP_OFS_CTRL, 8'h00);
    pin(0);
    flags(1, 1);
    rd(EIP_OFS_CTRL, 8'h08);
    vec_ack;
    flags(0, 0);
    wait_n(8);
    flags(0, 0);
    pin(1);
    wr(EIP_OFS_CTRL, 8'h02);
    pin(0);
    flags(1, 0);
    rd(EIP_OFS_CTRL, 8'h0a);
    wr(EIP_OFS_CTRL, 8'h00);
    flags(1, 1);
    cpu_int_mask <= 1'b1;
    flags(1, 0);
    cpu_int_mask <= 1'b0;
    wr(EIP_OFS_CTRL, 8'h04);
    flags(0, 0);
    rd(EIP_OFS_CTRL, 8'h00);
    pin(1);
    pin(0);
    flags(1, 1);
    wr(EIP_OFS_CTRL, 8'h04);
    pin(1);
    // level mode: both orders of acknowledge and pin return
    wr(EIP_OFS_CTRL, 8'h01);
    pin(0);
    flags(1, 1);
    vec_ack;
    flags(1, 1);
    wr(EIP_OFS_CTRL, 8'h03);
    flags(1, 0);
    pin(1);
    flags(0, 0);
    wr(EIP_OFS_CTRL, 8'h01);
    pin(0);
    pin(1);
    flags(1, 1);
    wr(EIP_OFS_CTRL, 8'h05);
    flags(0, 0);
    // acknowledge in the last cycle before the filtered pin rises
    pin(0);
    u_src.drive(1'b1);
    wait_n(1);
    vec_ack;
    flags(0, 0);
    // break protection of the software acknowledge
    wr(EIP_OFS_CTRL, 8'h00);
    pin(0);
    break_active <= 1'b1;
    wr(EIP_OFS_CTRL, 8'h04);
    flags(1, 1);
    wr(EIP_OFS_BRK, 8'h80);
    rd(EIP_OFS_BRK, 8'h80);
    wr(EIP_OFS_CTRL, 8'h04);
    flags(0, 0);
    pin(1);
    pin(0);
    vec_ack;
    flags(0, 0);
    break_active <= 1'b0;
    flags(0, 0);
    wr(EIP_OFS_BRK, 8'h00);
    // reset in level mode with the pin still low
    pin(1);
    wr(EIP_OFS_CTRL, 8'h01);
    pin(0);
    flags(1, 1);
    rst <= 1'b1;
    flags(0, 0);
    u_src.drive(1'b1);
    wait_n(4);
    rst <= 1'b0;
    wait_n(4);
    rd(EIP_OFS_CTRL, 8'h00);
    wrap_up;
  end
endmodule
